/* File: logic/audio_serial_pdm_clock_config.sv */
// Configuration and status bank of an audio serial controller: stop on
// empty, hung timeout, companding, LCD/camera, clock and PDM settings.
// Assumes one clock, a plain register port and a core that reports
// FIFO movement, empty state and its DMA state words.
//
// Added by the designer: the address-and-strobe port.
`default_nettype none
module audio_serial_pdm_clock_config
    import audio_serial_cfg_pkg::*;
#(
    parameter int unsigned SAMPLE_W = 16
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  clk_en_i,
    // Register port
    input  wire logic [audio_serial_cfg_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [audio_serial_cfg_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                  wr_i,
    input  wire logic                  rd_i,
    output logic [audio_serial_cfg_pkg::DATA_W-1:0]      rdata_o,
    // Core status
    input  wire logic                  tx_fifo_empty_i,
    input  wire logic                  tx_fifo_move_i,
    input  wire logic                  rx_fifo_move_i,
    input  wire logic                  tx_busy_i,
    input  wire logic                  tx_fifo_rst_i,
    input  wire logic                  rx_fifo_rst_i,
    input  wire logic [31:0]           rx_dma_state_i,
    input  wire logic [31:0]           dma_state_two_i,
    // Sample paths
    input  wire logic                  tx_valid_i,
    input  wire logic [SAMPLE_W-1:0]   tx_sample_i,
    input  wire logic [SAMPLE_W-1:0]   rx_sample_i,
    output logic [SAMPLE_W-1:0]        rx_sample_o,
    output logic [SAMPLE_W-1:0]        tx_sample_o,
    output logic                       tx_valid_o,
    output logic                       tx_ready_o,
    // Serial gating and events
    output logic                       clock_gate_en_o,
    output logic                       tx_timeout_o,
    output logic                       rx_timeout_o,
    // Decoded controls
    output logic                       fifo_power_on_o,
    output logic                       lcd_mode_en_o,
    output logic                       camera_mode_en_o,
    output logic                       camera_internal_valid_en_o,
    output logic                       ext_converter_start_en_o,
    output logic                       audio_pll_select_o,
    output logic [7:0]                 mclk_integral_divider_o,
    output logic [5:0]                 mclk_frac_numerator_o,
    output logic [5:0]                 mclk_frac_denominator_o,
    output logic [5:0]                 rx_sample_width_o,
    output logic [5:0]                 tx_sample_width_o,
    output logic [5:0]                 rx_bitclock_divider_o,
    output logic [5:0]                 tx_bitclock_divider_o,
    output logic                       tx_highpass_bypass_o,
    output logic [7:0]                 rx_downsample_ratio_o,
    output logic [9:0]                 tx_upsample_ratio_o,
    output logic                       density_to_pulsecode_en_o,
    output logic                       pulsecode_to_density_en_o,
    output logic                       rx_pdm_en_o,
    output logic                       tx_pdm_en_o,
    output logic [9:0]                 tx_density_freq_param_o,
    output logic [9:0]                 tx_pulsecode_freq_param_o
);
    import audio_serial_cfg_pkg::*;

    // ---------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------
    logic [31:0] stop_and_companding_conf_reg;
    logic [31:0] fifo_power_conf_reg;
    logic [31:0] lcd_camera_conf_reg;
    logic [31:0] master_clock_divider_reg;
    logic [31:0] sample_width_bitclock_conf_reg;
    logic [31:0] pulse_density_conf_reg;
    logic [31:0] pulse_density_freq_conf_reg;
    logic [31:0] fifo_timeout_conf_reg;
    logic [31:0] rx_dma_state_reg;
    logic [31:0] dma_state_two_reg;
    logic [2:0]  status_reg;
    logic [31:0] rdata_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            stop_and_companding_conf_reg   <= RST_STOP_COMPAND;
            fifo_power_conf_reg            <= RST_FIFO_POWER;
            lcd_camera_conf_reg            <= RST_LCD_CAMERA;
            master_clock_divider_reg       <= RST_MCLK_DIV;
            sample_width_bitclock_conf_reg <= RST_SAMPLE_BCK;
            pulse_density_conf_reg         <= RST_PDM_CONF;
            pulse_density_freq_conf_reg    <= RST_PDM_FREQ;
            fifo_timeout_conf_reg          <= RST_FIFO_TIMEOUT;
        end else if (clk_en_i && wr_i) begin
            case (addr_i)
                OFF_STOP_COMPAND:  stop_and_companding_conf_reg <= wdata_i;
                OFF_FIFO_POWER:    fifo_power_conf_reg <= wdata_i;
                OFF_LCD_CAMERA:    lcd_camera_conf_reg <= wdata_i;
                OFF_MCLK_DIV:      master_clock_divider_reg <= wdata_i;
                OFF_SAMPLE_BCK:    sample_width_bitclock_conf_reg <= wdata_i;
                OFF_PDM_CONF:      pulse_density_conf_reg <= wdata_i;
                OFF_PDM_FREQ:      pulse_density_freq_conf_reg <= wdata_i;
                OFF_FIFO_TIMEOUT:  fifo_timeout_conf_reg <= wdata_i;
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Status capture
    // ---------------------------------------------------------------
    // FIFO resets stretch to a fixed length so software can poll them
    logic [3:0] tx_rst_cnt_reg;
    logic [3:0] rx_rst_cnt_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            tx_rst_cnt_reg <= 4'h0;
            rx_rst_cnt_reg <= 4'h0;
        end else if (clk_en_i) begin
            if (tx_fifo_rst_i)
                tx_rst_cnt_reg <= FIFO_RST_CYCLES;
            else if (tx_rst_cnt_reg != 4'h0)
                tx_rst_cnt_reg <= tx_rst_cnt_reg - 4'h1;
            if (rx_fifo_rst_i)
                rx_rst_cnt_reg <= FIFO_RST_CYCLES;
            else if (rx_rst_cnt_reg != 4'h0)
                rx_rst_cnt_reg <= rx_rst_cnt_reg - 4'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rx_dma_state_reg  <= RST_DMA_STATE;
            dma_state_two_reg <= RST_DMA_STATE;
            status_reg        <= 3'h1;
        end else if (clk_en_i) begin
            rx_dma_state_reg  <= rx_dma_state_i;
            dma_state_two_reg <= dma_state_two_i;
            status_reg[B_TX_IDLE] <= ~tx_busy_i;
            status_reg[B_TX_RSTB] <= (tx_rst_cnt_reg != 4'h0);
            status_reg[B_RX_RSTB] <= (rx_rst_cnt_reg != 4'h0);
        end
    end

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (clk_en_i) begin
            if (rd_i) begin
                case (addr_i)
                    OFF_RX_DMA_STATE:  rdata_reg <= rx_dma_state_reg;
                    OFF_DMA_STATE_TWO: rdata_reg <= dma_state_two_reg;
                    OFF_STOP_COMPAND:  rdata_reg <= stop_and_companding_conf_reg;
                    OFF_FIFO_POWER:    rdata_reg <= fifo_power_conf_reg;
                    OFF_LCD_CAMERA:    rdata_reg <= lcd_camera_conf_reg;
                    OFF_MCLK_DIV:      rdata_reg <= master_clock_divider_reg;
                    OFF_SAMPLE_BCK:    rdata_reg <= sample_width_bitclock_conf_reg;
                    OFF_PDM_CONF:      rdata_reg <= pulse_density_conf_reg;
                    OFF_PDM_FREQ:      rdata_reg <= pulse_density_freq_conf_reg;
                    OFF_FIFO_TIMEOUT:  rdata_reg <= fifo_timeout_conf_reg;
                    OFF_FIFO_RST_IDLE: rdata_reg <= {29'h0, status_reg};
                    default:           rdata_reg <= 32'h0000_0000;
                endcase
            end else begin
                rdata_reg <= 32'h0000_0000;
            end
        end
    end
    assign rdata_o = rdata_reg;

    // ---------------------------------------------------------------
    // Hung counter and timeout events
    // ---------------------------------------------------------------
    logic       to_en;
    logic [7:0] to_value;
    logic [7:0] tx_hung_reg;
    logic [7:0] rx_hung_reg;
    logic       tx_timeout_reg;
    logic       rx_timeout_reg;

    assign to_en    = fifo_timeout_conf_reg[B_TO_EN];
    assign to_value = fifo_timeout_conf_reg[B_TO_VALUE +: 8];

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            tx_hung_reg <= 8'h00;
            rx_hung_reg <= 8'h00;
        end else if (clk_en_i) begin
            // Saturate at the threshold so the event fires once per stall
            if (!to_en || tx_fifo_move_i)
                tx_hung_reg <= 8'h00;
            else if (tx_hung_reg != to_value)
                tx_hung_reg <= tx_hung_reg + 8'h01;
            if (!to_en || rx_fifo_move_i)
                rx_hung_reg <= 8'h00;
            else if (rx_hung_reg != to_value)
                rx_hung_reg <= rx_hung_reg + 8'h01;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            tx_timeout_reg <= 1'b0;
            rx_timeout_reg <= 1'b0;
        end else if (clk_en_i) begin
            tx_timeout_reg <= to_en && !tx_fifo_move_i
                && (tx_hung_reg + 8'h01 == to_value);
            rx_timeout_reg <= to_en && !rx_fifo_move_i
                && (rx_hung_reg + 8'h01 == to_value);
        end
    end
    assign tx_timeout_o = tx_timeout_reg;
    assign rx_timeout_o = rx_timeout_reg;

    // ---------------------------------------------------------------
    // Companding stage
    // ---------------------------------------------------------------
    // Simple stand-ins, square law or three-quarter gain when comp is set; exact curves belong to the core
    function automatic logic [SAMPLE_W-1:0] compand(
        input logic [SAMPLE_W-1:0] s,
        input logic                comp
    );
        logic [2*SAMPLE_W-1:0] sq;
        sq = s * s;
        if (comp)
            compand = {1'b0, s[SAMPLE_W-1:1]} + {2'b00, s[SAMPLE_W-1:2]};
        else
            compand = sq[2*SAMPLE_W-1:SAMPLE_W];
    endfunction

    // Gain shift: 0 halves, 1 unity, 2 doubles, 3 quadruples
    function automatic logic [SAMPLE_W-1:0] gain_shift(
        input logic [SAMPLE_W-1:0] s,
        input logic [1:0]          code
    );
        case (code)
            2'h0:    gain_shift = {s[SAMPLE_W-1], s[SAMPLE_W-1:1]};
            2'h1:    gain_shift = s;
            2'h2:    gain_shift = {s[SAMPLE_W-2:0], 1'b0};
            default: gain_shift = {s[SAMPLE_W-3:0], 2'b00};
        endcase
    endfunction

    logic [SAMPLE_W-1:0] rx_sample_reg;
    logic [SAMPLE_W-1:0] tx_comp;
    logic [SAMPLE_W-1:0] tx_path;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rx_sample_reg <= '0;
        end else if (clk_en_i) begin
            if (stop_and_companding_conf_reg[B_RX_BYPASS])
                rx_sample_reg <= rx_sample_i;
            else
                rx_sample_reg <= compand(rx_sample_i,
                    stop_and_companding_conf_reg[B_RX_SEL]);
        end
    end
    assign rx_sample_o = rx_sample_reg;

    assign tx_comp = stop_and_companding_conf_reg[B_TX_BYPASS] ? tx_sample_i
        : compand(tx_sample_i, stop_and_companding_conf_reg[B_TX_SEL]);

    // In PDM mode the gain chain runs; high-pass stage is skippable
    always_comb begin
        tx_path = tx_comp;
        if (pulse_density_conf_reg[B_TX_PDM_EN]) begin
            if (!pulse_density_conf_reg[B_HP_BYPASS])
                tx_path = gain_shift(tx_path,
                    pulse_density_conf_reg[B_HP_SHIFT +: 2]);
            tx_path = gain_shift(tx_path,
                pulse_density_conf_reg[B_LP_SHIFT +: 2]);
            tx_path = gain_shift(tx_path,
                pulse_density_conf_reg[B_SINC_SHIFT +: 2]);
            tx_path = gain_shift(tx_path,
                pulse_density_conf_reg[B_SD_SHIFT +: 2]);
        end
    end

    // ---------------------------------------------------------------
    // LCD output repetition
    // ---------------------------------------------------------------
    logic [SAMPLE_W-1:0] tx_out_reg;
    logic                tx_valid_reg;
    logic [1:0]          rep_cnt_reg;
    logic [1:0]          rep_total;

    // Write-twice emits twice; pair duplicate repeats the pair word too
    always_comb begin
        rep_total = 2'h0;
        if (lcd_camera_conf_reg[B_LCD_EN]) begin
            if (lcd_camera_conf_reg[B_LCD_TWICE])
                rep_total = rep_total + 2'h1;
            if (lcd_camera_conf_reg[B_LCD_PAIR])
                rep_total = rep_total + 2'h1;
        end
    end

    assign tx_ready_o = (rep_cnt_reg == 2'h0);

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            tx_out_reg   <= '0;
            tx_valid_reg <= 1'b0;
            rep_cnt_reg  <= 2'h0;
        end else if (clk_en_i) begin
            if (rep_cnt_reg != 2'h0) begin
                tx_valid_reg <= 1'b1;
                rep_cnt_reg  <= rep_cnt_reg - 2'h1;
            end else if (tx_valid_i) begin
                tx_out_reg   <= tx_path;
                tx_valid_reg <= 1'b1;
                rep_cnt_reg  <= rep_total;
            end else begin
                tx_valid_reg <= 1'b0;
            end
        end
    end
    assign tx_sample_o = tx_out_reg;
    assign tx_valid_o  = tx_valid_reg;

    // ---------------------------------------------------------------
    // Clock gating and decoded controls
    // ---------------------------------------------------------------
    logic clock_gate_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i)
            clock_gate_reg <= 1'b1;
        else if (clk_en_i)
            clock_gate_reg <= !(stop_and_companding_conf_reg[B_TX_STOP]
                && tx_fifo_empty_i);
    end
    assign clock_gate_en_o = clock_gate_reg;

    // Power-down wins over power-up when both are forced
    assign fifo_power_on_o = !fifo_power_conf_reg[B_FORCE_PD]
        && fifo_power_conf_reg[B_FORCE_PU];
    assign lcd_mode_en_o    = lcd_camera_conf_reg[B_LCD_EN];
    assign camera_mode_en_o = lcd_camera_conf_reg[B_CAM_EN];
    assign camera_internal_valid_en_o = lcd_camera_conf_reg[B_CAM_VALID];
    assign ext_converter_start_en_o = lcd_camera_conf_reg[B_EXT_START];
    assign audio_pll_select_o = master_clock_divider_reg[B_APLL_SEL];
    assign mclk_integral_divider_o =
        master_clock_divider_reg[B_MCLK_INT +: 8];
    assign mclk_frac_numerator_o =
        master_clock_divider_reg[B_MCLK_NUM +: 6];
    assign mclk_frac_denominator_o =
        master_clock_divider_reg[B_MCLK_DEN +: 6];
    assign rx_sample_width_o =
        sample_width_bitclock_conf_reg[B_RX_WIDTH +: 6];
    assign tx_sample_width_o =
        sample_width_bitclock_conf_reg[B_TX_WIDTH +: 6];
    assign rx_bitclock_divider_o =
        sample_width_bitclock_conf_reg[B_RX_BCK +: 6];
    assign tx_bitclock_divider_o =
        sample_width_bitclock_conf_reg[B_TX_BCK +: 6];
    assign tx_highpass_bypass_o = pulse_density_conf_reg[B_HP_BYPASS];
    assign rx_downsample_ratio_o = pulse_density_conf_reg[B_RX_DSR128]
        ? RX_DSR_HIGH : RX_DSR_LOW;
    assign tx_upsample_ratio_o = TX_UPS_UNIT
        * {6'h0, pulse_density_conf_reg[B_OSR +: 4]};
    assign density_to_pulsecode_en_o = pulse_density_conf_reg[B_D2P_EN];
    assign pulsecode_to_density_en_o = pulse_density_conf_reg[B_P2D_EN];
    assign rx_pdm_en_o = pulse_density_conf_reg[B_RX_PDM_EN];
    assign tx_pdm_en_o = pulse_density_conf_reg[B_TX_PDM_EN];
    assign tx_density_freq_param_o =
        pulse_density_freq_conf_reg[B_FP +: 10];
    assign tx_pulsecode_freq_param_o =
        pulse_density_freq_conf_reg[B_FS +: 10];
endmodule
`default_nettype wire

/* File: logic/audio_serial_cfg_pkg.sv */
// Constants for the audio serial configuration and status block.
// Assumes a single 250 MHz clock and a plain register port.
`default_nettype none
package audio_serial_cfg_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    // Register byte offsets
    localparam logic [7:0] OFF_RX_DMA_STATE    = 8'h6c;
    localparam logic [7:0] OFF_DMA_STATE_TWO   = 8'h70;
    localparam logic [7:0] OFF_STOP_COMPAND    = 8'ha0;
    localparam logic [7:0] OFF_FIFO_POWER      = 8'ha4;
    localparam logic [7:0] OFF_LCD_CAMERA      = 8'ha8;
    localparam logic [7:0] OFF_MCLK_DIV        = 8'hac;
    localparam logic [7:0] OFF_SAMPLE_BCK      = 8'hb0;
    localparam logic [7:0] OFF_PDM_CONF        = 8'hb4;
    localparam logic [7:0] OFF_PDM_FREQ        = 8'hb8;
    localparam logic [7:0] OFF_FIFO_TIMEOUT    = 8'hbc;
    localparam logic [7:0] OFF_FIFO_RST_IDLE   = 8'hc0;
    // stop_and_companding_conf fields
    localparam int unsigned B_TX_STOP   = 0;
    localparam int unsigned B_RX_BYPASS = 1;
    localparam int unsigned B_RX_SEL    = 2;
    localparam int unsigned B_TX_BYPASS = 3;
    localparam int unsigned B_TX_SEL    = 4;
    // fifo_power_conf fields
    localparam int unsigned B_FORCE_PU  = 0;
    localparam int unsigned B_FORCE_PD  = 1;
    // lcd_camera_conf fields
    localparam int unsigned B_CAM_VALID = 0;
    localparam int unsigned B_EXT_START = 1;
    localparam int unsigned B_LCD_EN    = 2;
    localparam int unsigned B_LCD_PAIR  = 3;
    localparam int unsigned B_LCD_TWICE = 4;
    localparam int unsigned B_CAM_EN    = 5;
    // master_clock_divider fields
    localparam int unsigned B_MCLK_INT  = 0;   // 8 bits
    localparam int unsigned B_MCLK_NUM  = 8;   // 6 bits
    localparam int unsigned B_MCLK_DEN  = 14;  // 6 bits
    localparam int unsigned B_APLL_SEL  = 21;
    // sample_width_bitclock_conf fields
    localparam int unsigned B_TX_BCK    = 0;   // 6 bits
    localparam int unsigned B_RX_BCK    = 6;   // 6 bits
    localparam int unsigned B_TX_WIDTH  = 12;  // 6 bits
    localparam int unsigned B_RX_WIDTH  = 18;  // 6 bits
    // pulse_density_conf fields
    localparam int unsigned B_TX_PDM_EN = 0;
    localparam int unsigned B_RX_PDM_EN = 1;
    localparam int unsigned B_P2D_EN    = 2;
    localparam int unsigned B_D2P_EN    = 3;
    localparam int unsigned B_OSR       = 4;   // 4 bits
    localparam int unsigned B_HP_SHIFT  = 8;
    localparam int unsigned B_LP_SHIFT  = 10;
    localparam int unsigned B_SINC_SHIFT = 12;
    localparam int unsigned B_SD_SHIFT  = 14;
    localparam int unsigned B_RX_DSR128 = 16;
    localparam int unsigned B_HP_BYPASS = 17;
    // pulse_density_freq_conf fields
    localparam int unsigned B_FS        = 0;   // 10 bits
    localparam int unsigned B_FP        = 10;  // 10 bits
    // fifo_timeout_conf fields
    localparam int unsigned B_TO_VALUE  = 0;   // 8 bits
    localparam int unsigned B_TO_EN     = 11;
    // fifo_reset_idle_state fields
    localparam int unsigned B_TX_IDLE   = 0;
    localparam int unsigned B_TX_RSTB   = 1;
    localparam int unsigned B_RX_RSTB   = 2;
    // Reset values
    localparam logic [31:0] RST_STOP_COMPAND = 32'h0000_0000;
    localparam logic [31:0] RST_FIFO_POWER   = 32'h0000_0000;
    localparam logic [31:0] RST_LCD_CAMERA   = 32'h0000_0000;
    localparam logic [31:0] RST_MCLK_DIV     = 32'h0000_0004;
    localparam logic [31:0] RST_SAMPLE_BCK   = 32'h0041_0606;
    localparam logic [31:0] RST_PDM_CONF     = 32'h0001_5520;
    localparam logic [31:0] RST_PDM_FREQ     = 32'h0003_c3c0;
    localparam logic [31:0] RST_FIFO_TIMEOUT = 32'h0000_0010;
    localparam logic [31:0] RST_DMA_STATE    = 32'h0000_0000;
    // Down-sampling ratios of receive filter group one and the transmit up-sampling unit
    localparam logic [7:0] RX_DSR_HIGH = 8'h80;
    localparam logic [7:0] RX_DSR_LOW  = 8'h40;
    localparam logic [9:0] TX_UPS_UNIT = 10'h040;
    // FIFO reset length in cycles
    localparam logic [3:0] FIFO_RST_CYCLES = 4'h4;
endpackage
`default_nettype wire

/* File: bench/core_stub.sv */
// Far-side core stand-in: FIFO data moves every cycle unless stalled.
// Assumes the bench drives stall_i; a stall also reads as an empty FIFO.
`default_nettype none
module core_stub (
    input  wire logic ref_clk_i,
    input  wire logic stall_i,
    output logic      tx_fifo_empty_o,
    output logic      move_o
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge ref_clk_i) begin
        move_o          <= !stall_i;
        tx_fifo_empty_o <= stall_i;
    end
endmodule
`default_nettype wire

/* File: bench/audio_cfg_monitor.sv */
// Concurrent checks on the configuration bank ports.
// Assumes clk_en_i stays high; the checks still sample every rising ref_clk_i edge while the bank is frozen.
`default_nettype none
module audio_cfg_monitor
    import audio_serial_cfg_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        reset_n_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        tx_fifo_move_i,
    input wire logic        tx_fifo_rst_i,
    input wire logic [31:0] rx_dma_state_i,
    input wire logic        tx_timeout_o,
    input wire logic [7:0]  mclk_integral_divider_o,
    input wire logic [7:0]  rx_downsample_ratio_o,
    input wire logic [9:0]  tx_upsample_ratio_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    property p_pulse; tx_timeout_o |=> !tx_timeout_o; endproperty
    a_pulse: assert property (p_pulse) else $error("long pulse");
    property p_move; tx_fifo_move_i [*2] |=> !tx_timeout_o; endproperty
    a_move: assert property (p_move) else $error("moving yet hung");
    property p_mclk; wr_i && addr_i == OFF_MCLK_DIV
        |=> mclk_integral_divider_o == $past(wdata_i[7:0]); endproperty
    a_mclk: assert property (p_mclk) else $error("divider");
    property p_dsr; wr_i && addr_i == OFF_PDM_CONF |=> rx_downsample_ratio_o
        == ($past(wdata_i[B_RX_DSR128]) ? 8'h80 : 8'h40); endproperty
    a_dsr: assert property (p_dsr) else $error("downsample");
    property p_ups; wr_i && addr_i == OFF_PDM_CONF
        |=> tx_upsample_ratio_o == 10'h040 * $past(wdata_i[7:4]); endproperty
    a_ups: assert property (p_ups) else $error("upsample");
    property p_rst; tx_fifo_rst_i ##2 rd_i && addr_i == OFF_FIFO_RST_IDLE
        |=> rdata_o[B_TX_RSTB]; endproperty
    a_rst: assert property (p_rst) else $error("reset not busy");
    property p_rdone; tx_fifo_rst_i ##1 !tx_fifo_rst_i [*7] ##1 rd_i
        && addr_i == OFF_FIFO_RST_IDLE |=> !rdata_o[B_TX_RSTB]; endproperty
    a_rdone: assert property (p_rdone) else $error("reset stuck");
    property p_dma; rd_i && addr_i == OFF_RX_DMA_STATE
        |=> rdata_o == $past(rx_dma_state_i, 2); endproperty
    a_dma: assert property (p_dma) else $error("dma state");
    c_hung: cover property (tx_timeout_o);
    c_rst: cover property (tx_fifo_rst_i ##2 rd_i);
    c_dsr: cover property (rx_downsample_ratio_o == 8'h80);
endmodule
bind audio_serial_pdm_clock_config audio_cfg_monitor mon (.*);
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the configuration bank.
// Assumes core_stub on the far side and the bound monitor.
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
n_errors++; $display("BAD %0t %h", $time, a); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import audio_serial_cfg_pkg::*;
    int n_errors = 0;
    int samples_checked = 0;
    int seen;
    logic ref_clk_i = 1'b0, reset_n_i = 1'b0, clk_en_i = 1'b1, wr_i = 1'b0;
    logic rd_i = 1'b0, stall = 1'b0, tx_busy_i = 1'b0, tx_fifo_rst_i = 1'b0;
    logic rx_fifo_rst_i = 1'b0, tx_valid_i = 1'b0, tx_fifo_empty_i;
    logic tx_fifo_move_i, rx_fifo_move_i;
    logic [7:0] addr_i = 8'h00, mclk_integral_divider_o, rx_downsample_ratio_o;
    logic [31:0] wdata_i = '0, rx_dma_state_i = '0, dma_state_two_i = '0;
    logic [31:0] rdata_o, d;
    logic [15:0] tx_sample_i = '0, rx_sample_i = '0, rx_sample_o, tx_sample_o;
    logic [9:0] tx_upsample_ratio_o, tx_density_freq_param_o;
    logic [9:0] tx_pulsecode_freq_param_o;
    logic [5:0] mclk_frac_numerator_o, mclk_frac_denominator_o;
    logic [5:0] rx_sample_width_o, tx_sample_width_o;
    logic [5:0] rx_bitclock_divider_o, tx_bitclock_divider_o;
    logic tx_valid_o, tx_ready_o, clock_gate_en_o, tx_timeout_o;
    logic rx_timeout_o, fifo_power_on_o, lcd_mode_en_o, camera_mode_en_o;
    logic camera_internal_valid_en_o, ext_converter_start_en_o;
    logic audio_pll_select_o, tx_highpass_bypass_o, rx_pdm_en_o, tx_pdm_en_o;
    logic density_to_pulsecode_en_o, pulsecode_to_density_en_o;
    audio_serial_pdm_clock_config dut (.*);
    core_stub far (.ref_clk_i(ref_clk_i), .stall_i(stall),
        .tx_fifo_empty_o(tx_fifo_empty_i), .move_o(tx_fifo_move_i));
    assign rx_fifo_move_i = tx_fifo_move_i;
    initial forever #2 ref_clk_i = !ref_clk_i;
    // One strobe cycle; read data taken in the cycle after it
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] v);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= w;
        rd_i    <= !w;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
        rd_i    <= 1'b0;
        @(negedge ref_clk_i);
        d = rdata_o;
    endtask
    task automatic t_cfg;
        bus(1'b0, OFF_MCLK_DIV, '0);
        `CHK(d, RST_MCLK_DIV)
        bus(1'b1, OFF_MCLK_DIV, 32'h0020_9c05);
        `CHK({audio_pll_select_o, mclk_integral_divider_o}, 9'h105)
        bus(1'b1, OFF_PDM_CONF, 32'h0001_0030);
        `CHK({rx_downsample_ratio_o, tx_upsample_ratio_o}, 18'h200c0)
        bus(1'b1, OFF_PDM_CONF, 32'h0000_0010);
        `CHK({rx_downsample_ratio_o, tx_upsample_ratio_o}, 18'h10040)
        bus(1'b1, OFF_RX_DMA_STATE, '1);
        bus(1'b0, OFF_RX_DMA_STATE, '0);
        `CHK(d, 32'h0)
        @(posedge ref_clk_i) rx_dma_state_i <= 32'h0000_a5c3;
        bus(1'b0, OFF_RX_DMA_STATE, '0);
        `CHK(d, 32'h0000_a5c3)
        bus(1'b0, 8'h04, '0);
        `CHK(d, 32'h0)
    endtask
    task automatic t_ctl;
        bus(1'b1, OFF_FIFO_POWER, 32'h1);
        `CHK(fifo_power_on_o, 1'b1)
        bus(1'b1, OFF_LCD_CAMERA, 32'h24);
        `CHK({lcd_mode_en_o, camera_mode_en_o}, 2'b11)
        bus(1'b1, OFF_SAMPLE_BCK, 32'h8a_3c41);
        `CHK({rx_sample_width_o, tx_sample_width_o}, 12'h8a3)
        `CHK({rx_bitclock_divider_o, tx_bitclock_divider_o}, 12'hc41)
        bus(1'b1, OFF_PDM_FREQ, 32'h1_4c03);
        `CHK(tx_density_freq_param_o, 10'h053)
        `CHK(tx_pulsecode_freq_param_o, 10'h003)
        bus(1'b1, OFF_PDM_CONF, 32'h5);
        `CHK({rx_pdm_en_o, tx_pdm_en_o}, 2'b01)
        `CHK(density_to_pulsecode_en_o, 1'b0)
        `CHK(pulsecode_to_density_en_o, 1'b1)
        bus(1'b1, OFF_STOP_COMPAND, 32'h3);
        @(posedge ref_clk_i);
        stall       <= 1'b1;
        rx_sample_i <= 16'h1234;
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        `CHK(clock_gate_en_o, 1'b0)
        `CHK(rx_sample_o, 16'h1234)
        @(posedge ref_clk_i) stall <= 1'b0;
    endtask
    // Stall long past the limit: exactly one pulse per direction
    task automatic t_time;
        bus(1'b1, OFF_FIFO_TIMEOUT, 32'h0000_0805);
        seen = 0;
        @(posedge ref_clk_i) stall <= 1'b1;
        repeat (20) @(negedge ref_clk_i)
            seen += (tx_timeout_o === 1'b1) + (rx_timeout_o === 1'b1);
        @(posedge ref_clk_i) stall <= 1'b0;
        `CHK(seen, 2)
    endtask
    task automatic t_stat;
        @(posedge ref_clk_i) tx_fifo_rst_i <= 1'b1;
        @(posedge ref_clk_i) tx_fifo_rst_i <= 1'b0;
        bus(1'b0, OFF_FIFO_RST_IDLE, '0);
        `CHK(d[2:0], 3'b011)
        @(posedge ref_clk_i) tx_busy_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        bus(1'b0, OFF_FIFO_RST_IDLE, '0);
        `CHK(d[2:0], 3'b000)
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        t_cfg();
        t_ctl();
        t_time();
        t_stat();
        close_out();
    end
    initial begin
        #4000;
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
